//--- inc/pci_defs.vh
// Register offsets, field positions and reset values for the PHY control and mask bank
`ifndef PCI_DEFS_VH
`define PCI_DEFS_VH
`define PCI_ADDR_CTRL 5'h17
`define PCI_ADDR_MASK 5'h18
`define PCI_CTRL_PHONE_FOUND 15
`define PCI_CTRL_PHONE_START 14
`define PCI_CTRL_DIAG_MODE 13
`define PCI_CTRL_RETRY_HI 12
`define PCI_CTRL_RETRY_LO 11
`define PCI_CTRL_TXC_ALT 6
`define PCI_CTRL_JABBER_DIS 5
`define PCI_CTRL_SQE_EN 4
`define PCI_CTRL_LOOP_DIS 3
`define PCI_CTRL_PREAMBLE_EN 2
`define PCI_CTRL_FORCE_IRQ 0
`define PCI_CTRL_WMASK 16'h787d
`define PCI_CTRL_RST 16'h380c
`define PCI_MASK_WMASK 16'h07ff
`define PCI_MASK_RST 16'h0000
`define PCI_MASK_OUT_EN 0
`define PCI_EVT_W 10
`define PCI_EVT_PHONE 9
`define PCI_DELAY_NS 2
`define PCI_STRAP_SETTLE 2'h3
`endif

//--- core/pci_sync2.v
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module pci_sync2 #(
	parameter W = 1
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire [W-1:0] d_in,
	output reg [W-1:0] q_out
);
	reg [W-1:0] meta_r;
	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_r <= {W{1'b0}};
			q_out <= {W{1'b0}};
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule // pci_sync2
`default_nettype wire

//--- core/pci_phy_ctrl.v
// PHY control and interrupt mask register bank with interrupt pin logic
// Summary of operation
// - Bit 15 reports phone found, read-only, resets to zero.
// - Writing start bit 14 launches detection and clears the result.
// - Start bit self-clears on detection done; result then latched.
// - Bit 13 selects link analysis (1) or TDR (0); resets to 1.
// - In TDR mode, link pulses are ignored and no link forms.
// - Bits 12:11 give one to four attempts before downshift; reset 11.
// - Bit 6 makes TXC delay opposite of RXC; reset from strap.
// - Interface mode and bit 6 pick TXC/RXC delays of 0 or 2 ns.
// - Bit 5 disables jabber, bit 4 enables heartbeat; both reset 0.
// - Bit 3 disables pair loopback in half-duplex; resets to 1.
// - Bit 2 enables 10Base-T preamble generation; resets to 1.
// - Force bit 0 asserts interrupt pin low; clearing releases it unless mask bit 0 is set and an enabled event is pending.
// - Mask bits 10..1 enable each event's interrupt; reset zero.
// - Mask bit 0 enables pin; low while interrupt pending.
// - Pending is set when any enabled event flag is set.
// - Event flags latch high until read; reset zero.
// - Standby entered when TDR mode selected and link is down.
`timescale 1ns/1ps
`default_nettype none
`include "pci_defs.vh"
module pci_phy_ctrl (
	input wire clk_in,
	input wire sys_rst_in,
	input wire [4:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [15:0] reg_wdata_in,
	output reg [15:0] reg_rdata_out,
	input wire [2:0] mac_mode_in,
	input wire ref_clock_out_strap_low,
	input wire phone_done_in,
	input wire phone_found_in,
	input wire [`PCI_EVT_W-1:0] event_in,
	input wire status_rd_in,
	input wire link_up_in,
	input wire link_pulse_in,
	output reg phone_start_out,
	output reg link_allow_out,
	output reg link_pulse_out,
	output reg standby_out,
	output reg [1:0] retry_sel_out,
	output reg [2:0] retry_count_out,
	output reg jabber_dis_out,
	output reg sqe_en_out,
	output reg pair_echo_loop_disable,
	output reg preamble_en_out,
	output reg [1:0] txc_delay_ns_out,
	output reg [1:0] rxc_delay_ns_out,
	output reg [`PCI_EVT_W-1:0] event_flags_out,
	output reg irq_pending_out,
	output wire mgmt_irq_out_low,
	output wire mgmt_irq_oe_low
);
	reg [15:0] ctrl_r;
	reg [15:0] ctrl_nxt;
	reg [15:0] mask_r;
	reg [`PCI_EVT_W-1:0] flag_r;
	reg [`PCI_EVT_W-1:0] flag_nxt;
	// Edges seen since release while the strap crosses both sync flops
	reg [1:0] strap_cnt_r;
	reg [15:0] rdata_nxt;
	wire [`PCI_EVT_W-1:0] armed_nxt;
	wire irq_nxt;
	reg irq_drive_r;
	wire strap_s;
	wire [`PCI_EVT_W-1:0] event_s;
	wire [4:0] misc_s;
	wire ctrl_wr;
	wire mask_wr;
	wire tdr_mode;
	wire rgmii_dll;

	// Pin-level event sources cross into clk_in before use
	pci_sync2 #(.W(1)) u_strap (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.d_in(ref_clock_out_strap_low),
		.q_out(strap_s)
	);
	pci_sync2 #(.W(`PCI_EVT_W)) u_evt (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.d_in(event_in),
		.q_out(event_s)
	);
	pci_sync2 #(.W(5)) u_misc (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.d_in({phone_done_in, phone_found_in, link_up_in, link_pulse_in, status_rd_in}),
		.q_out(misc_s)
	);

	assign ctrl_wr = reg_wr_in && (reg_addr_in == `PCI_ADDR_CTRL);
	assign mask_wr = reg_wr_in && (reg_addr_in == `PCI_ADDR_MASK);
	assign tdr_mode = ~ctrl_r[`PCI_CTRL_DIAG_MODE];
	assign rgmii_dll = mac_mode_in[1];

	always @* begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			// Reserved and read-only bits keep their value
			ctrl_nxt = (ctrl_r & ~`PCI_CTRL_WMASK) | (reg_wdata_in & `PCI_CTRL_WMASK);
			if (reg_wdata_in[`PCI_CTRL_PHONE_START]) begin
				ctrl_nxt[`PCI_CTRL_PHONE_FOUND] = 1'b0;
			end
		end
		// Completion wins over a concurrent write so a done is never lost
		if (ctrl_r[`PCI_CTRL_PHONE_START] && misc_s[4]) begin
			ctrl_nxt[`PCI_CTRL_PHONE_START] = 1'b0;
			ctrl_nxt[`PCI_CTRL_PHONE_FOUND] = misc_s[3];
		end
	end

	always @* begin
		// Set wins over read-clear
		flag_nxt = flag_r;
		if (misc_s[0]) begin
			flag_nxt = {`PCI_EVT_W{1'b0}};
		end
		flag_nxt = flag_nxt | event_s;
		if (ctrl_r[`PCI_CTRL_PHONE_START] && misc_s[4]) begin
			flag_nxt[`PCI_EVT_PHONE] = 1'b1;
		end
	end

	// Unmapped addresses read as zero rather than stale data
	always @* begin
		rdata_nxt = 16'h0000;
		if (reg_addr_in == `PCI_ADDR_CTRL) begin
			rdata_nxt = ctrl_r & (`PCI_CTRL_WMASK | 16'h8000);
		end else if (reg_addr_in == `PCI_ADDR_MASK) begin
			rdata_nxt = mask_r & `PCI_MASK_WMASK;
		end
	end

	// Pin follows next-state flags so it asserts together with the flag
	assign armed_nxt = flag_nxt & mask_r[10:1];
	assign irq_nxt = ctrl_nxt[`PCI_CTRL_FORCE_IRQ]
		|| (mask_r[`PCI_MASK_OUT_EN] && (|armed_nxt));

	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_r <= `PCI_CTRL_RST;
			mask_r <= `PCI_MASK_RST;
			flag_r <= {`PCI_EVT_W{1'b0}};
			strap_cnt_r <= 2'h0;
			irq_drive_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			// Strap trusted only after both sync flops; a write ends the window
			if (strap_cnt_r != `PCI_STRAP_SETTLE) begin
				if (ctrl_wr) begin
					strap_cnt_r <= `PCI_STRAP_SETTLE;
				end else begin
					ctrl_r[`PCI_CTRL_TXC_ALT] <= ~strap_s;
					strap_cnt_r <= strap_cnt_r + 2'h1;
				end
			end
			if (mask_wr) begin
				mask_r <= reg_wdata_in & `PCI_MASK_WMASK;
			end
			flag_r <= flag_nxt;
			// Registered drive keeps glitches off the open-drain line
			irq_drive_r <= irq_nxt;
		end
	end

	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 16'h0000;
			phone_start_out <= 1'b0;
			link_allow_out <= 1'b0;
			link_pulse_out <= 1'b0;
			standby_out <= 1'b0;
			retry_sel_out <= 2'b11;
			retry_count_out <= 3'h4;
			jabber_dis_out <= 1'b0;
			sqe_en_out <= 1'b0;
			pair_echo_loop_disable <= 1'b1;
			preamble_en_out <= 1'b1;
			txc_delay_ns_out <= 2'h0;
			rxc_delay_ns_out <= 2'h0;
			event_flags_out <= {`PCI_EVT_W{1'b0}};
			irq_pending_out <= 1'b0;
		end else begin
			// Read data holds between reads so the master may take it late
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_nxt;
			end
			phone_start_out <= ctrl_r[`PCI_CTRL_PHONE_START];
			// TDR mode blocks link pulses and link bring-up
			link_allow_out <= ~tdr_mode;
			link_pulse_out <= misc_s[1] & ~tdr_mode;
			standby_out <= tdr_mode & ~misc_s[2];
			retry_sel_out <= ctrl_r[`PCI_CTRL_RETRY_HI:`PCI_CTRL_RETRY_LO];
			retry_count_out <= {1'b0, ctrl_r[`PCI_CTRL_RETRY_HI:`PCI_CTRL_RETRY_LO]} + 3'h1;
			jabber_dis_out <= ctrl_r[`PCI_CTRL_JABBER_DIS];
			sqe_en_out <= ctrl_r[`PCI_CTRL_SQE_EN];
			pair_echo_loop_disable <= ctrl_r[`PCI_CTRL_LOOP_DIS];
			preamble_en_out <= ctrl_r[`PCI_CTRL_PREAMBLE_EN];
			// Delays only matter in RGMII modes 10x and 11x
			if (mac_mode_in[2]) begin
				txc_delay_ns_out <= (rgmii_dll ^ ctrl_r[`PCI_CTRL_TXC_ALT])
					? 2'd`PCI_DELAY_NS : 2'h0;
				rxc_delay_ns_out <= rgmii_dll ? 2'd`PCI_DELAY_NS : 2'h0;
			end else begin
				txc_delay_ns_out <= 2'h0;
				rxc_delay_ns_out <= 2'h0;
			end
			event_flags_out <= flag_r;
			irq_pending_out <= |(flag_r & mask_r[10:1]);
		end
	end

	// Open-drain: enable low drives the pin low
	assign mgmt_irq_out_low = 1'b0;
	assign mgmt_irq_oe_low = ~irq_drive_r;
endmodule // pci_phy_ctrl
`default_nettype wire

//--- dv/pci_props.sv
// Checker for the PHY control bank ports
`timescale 1ns/1ps
`default_nettype none
module pci_props (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [2:0] mac_mode_in,
	input wire logic status_rd_in,
	input wire logic phone_done_in,
	input wire logic phone_start_out,
	input wire logic link_allow_out,
	input wire logic link_pulse_out,
	input wire logic [1:0] retry_sel_out,
	input wire logic [2:0] retry_count_out,
	input wire logic [1:0] rxc_delay_ns_out,
	input wire logic [9:0] event_flags_out,
	input wire logic irq_pending_out,
	input wire logic mgmt_irq_out_low
);
	logic [5:0] rd_r;
	// Sync flops delay the clear, so keep a short read history
	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_r <= 6'h00;
		end else begin
			rd_r <= {rd_r[4:0], status_rd_in};
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_pulse_gated: assert property (!link_allow_out |-> !link_pulse_out)
		else $error("link pulse passed in TDR mode");
	a_retry_count: assert property (retry_count_out == {1'b0, retry_sel_out} + 3'h1)
		else $error("retry count not select plus one");
	a_rxc_dll: assert property ((mac_mode_in[2:1] == 2'h3)[*3] |-> rxc_delay_ns_out == 2'h2)
		else $error("rx delay wrong in DLL mode");
	a_rxc_trace: assert property ((mac_mode_in[2:1] == 2'h2)[*3] |-> rxc_delay_ns_out == 2'h0)
		else $error("rx delay wrong in trace mode");
	a_pin_level: assert property (mgmt_irq_out_low == 1'b0)
		else $error("interrupt pin not driven low");
	a_pend_cause: assert property (irq_pending_out |-> |{event_flags_out, $past(event_flags_out)})
		else $error("pending without any flag");
	a_flag_hold: assert property (|($past(event_flags_out) & ~event_flags_out) |-> |rd_r)
		else $error("flag dropped without a status read");
	a_start_clear: assert property (phone_done_in[*2] |-> ##[0:4] !phone_start_out)
		else $error("start bit did not self-clear");
endmodule // pci_props
bind pci_phy_ctrl pci_props pci_props_inst (.clk_in, .sys_rst_in, .mac_mode_in, .status_rd_in,
	.phone_done_in, .phone_start_out, .link_allow_out, .link_pulse_out, .retry_sel_out,
	.retry_count_out, .rxc_delay_ns_out, .event_flags_out, .irq_pending_out, .mgmt_irq_out_low);
`default_nettype wire

//--- dv/pci_mgr_model.sv
// Management controller model on the register port
`timescale 1ns/1ps
`default_nettype none
module pci_mgr_model (
	input wire logic clk_in,
	input wire logic [15:0] rdata_in,
	output var logic [4:0] addr_out,
	output var logic wr_out,
	output var logic rd_out,
	output var logic [15:0] wdata_out
);
	initial begin
		addr_out = 5'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 16'h0000;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		// Registered answer stands from the read edge on; take it one edge later
		@(posedge clk_in);
		d = rdata_in;
	endtask
	// Result trusted only once start has self-cleared
	task automatic poll(output logic [15:0] d);
		d = 16'h4000;
		for (int i = 0; i < 20 && d[14] !== 1'b0; i++) rd(5'h17, d);
	endtask
endmodule // pci_mgr_model
`default_nettype wire

//--- dv/test_pci_phy_ctrl.sv
// Self-checking bench for the PHY control bank
`timescale 1ns/1ps
`default_nettype none
`include "pci_defs.vh"
module test_pci_phy_ctrl;
	logic clk_in, sys_rst_in, reg_wr_in, reg_rd_in, link_allow_out, link_pulse_out, standby_out;
	logic [4:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, v;
	logic [2:0] mac_mode_in = 3'h6;
	logic ref_clock_out_strap_low = 1'b0, link_up_in = 1'b0, link_pulse_in = 1'b1;
	logic phone_done_in = 1'b0, phone_found_in = 1'b0, status_rd_in = 1'b0;
	logic [9:0] event_in = 10'h000, event_flags_out;
	logic phone_start_out, jabber_dis_out, sqe_en_out, pair_echo_loop_disable, preamble_en_out;
	logic [1:0] retry_sel_out, txc_delay_ns_out, rxc_delay_ns_out;
	logic [2:0] retry_count_out;
	logic irq_pending_out, mgmt_irq_out_low, mgmt_irq_oe_low;
	int err_count = 0, n_tests = 0;
	pci_phy_ctrl pci_phy_ctrl_inst (.*);
	pci_mgr_model m (.clk_in, .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
		.wr_out(reg_wr_in), .rd_out(reg_rd_in), .wdata_out(reg_wdata_in));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		m.rd(a, v);
		chk(v, e);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		sys_rst_in = 1'b1;
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rdc(`PCI_ADDR_CTRL, 16'h384c);
		rdc(`PCI_ADDR_MASK, 16'h0000);
		rdc(5'h19, 16'h0000);
		chk({jabber_dis_out, sqe_en_out, pair_echo_loop_disable, preamble_en_out}, 16'h0003);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			mac_mode_in <= i[0] ? 3'h6 : 3'h4;
			m.wr(`PCI_ADDR_CTRL, {3'h1, i[1:0], 4'h0, i[1], 6'h0c});
			repeat (4) @(posedge clk_in);
			chk(retry_sel_out, i[1:0]);
			chk(retry_count_out, {1'b0, i[1:0]} + 3'h1);
			chk(txc_delay_ns_out, (i[0] ^ i[1]) ? 2'h2 : 2'h0);
			chk(rxc_delay_ns_out, i[0] ? 2'h2 : 2'h0);
			chk(link_pulse_out, 1'b1);
		end
		$display("test reset and fields done");
		m.wr(`PCI_ADDR_CTRL, 16'hbfff);
		rdc(`PCI_ADDR_CTRL, 16'h387d);
		chk(mgmt_irq_oe_low, 1'b0);
		m.wr(`PCI_ADDR_CTRL, 16'h0000);
		repeat (4) @(posedge clk_in);
		chk({mgmt_irq_oe_low, link_allow_out, link_pulse_out, standby_out}, 4'h9);
		m.wr(`PCI_ADDR_CTRL, 16'h4000);
		rdc(`PCI_ADDR_CTRL, 16'h4000);
		chk(phone_start_out, 1'b1);
		@(posedge clk_in);
		phone_done_in <= 1'b1;
		phone_found_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		phone_done_in <= 1'b0;
		m.poll(v);
		chk(v, 16'h8000);
		chk({phone_start_out, standby_out}, 2'h1);
		chk(event_flags_out, 16'h0200);
		m.wr(`PCI_ADDR_CTRL, 16'h4000);
		rdc(`PCI_ADDR_CTRL, 16'h4000);
		$display("test phone detect done");
		m.wr(`PCI_ADDR_MASK, 16'hffff);
		rdc(`PCI_ADDR_MASK, 16'h07ff);
		chk({irq_pending_out, mgmt_irq_oe_low}, 2'h2);
		@(posedge clk_in);
		status_rd_in <= 1'b1;
		@(posedge clk_in);
		status_rd_in <= 1'b0;
		event_in <= 10'h008;
		@(posedge clk_in);
		event_in <= 10'h000;
		repeat (6) @(posedge clk_in);
		chk({event_flags_out, irq_pending_out}, 16'h0011);
		m.wr(`PCI_ADDR_MASK, 16'h07ef);
		repeat (3) @(posedge clk_in);
		chk({irq_pending_out, mgmt_irq_oe_low}, 2'h1);
		@(posedge clk_in);
		status_rd_in <= 1'b1;
		event_in <= 10'h001;
		@(posedge clk_in);
		status_rd_in <= 1'b0;
		event_in <= 10'h000;
		repeat (6) @(posedge clk_in);
		chk(event_flags_out, 16'h0001);
		m.wr(`PCI_ADDR_MASK, 16'h07fe);
		repeat (3) @(posedge clk_in);
		chk({irq_pending_out, mgmt_irq_oe_low}, 2'h3);
		$display("test interrupt mask done");
		give_verdict();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_in);
		err_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		give_verdict();
	end
endmodule // test_pci_phy_ctrl
`default_nettype wire
